// file: include/eisf_cfg.svh
/*
 Register offsets, field positions, reset values and sense codes of the
 external interrupt front end.
 Assumes a 32-bit Avalon-MM slave; each register takes one aligned word.
*/
// Summary of operation
// - Each maskable pin owns a 2-bit sense field in a 16-bit register.
// - Code 00 requests while the pin is low.
// - Code 01 requests on each falling edge.
// - Code 10 requests on each rising edge.
// - Code 11 requests on both edges.
// - Status flag n sets when the selected condition of pin n occurs.
// - Software clears a flag by writing zero; flags read as current status.
// - Level mode: exception handling clears the flag only while pin is high.
// - Edge modes: exception handling clears the flag.
// - Transfer controller activation clears the flag when end-disable is zero.
// - Nonmaskable request always passes to the CPU at top priority.
// - Nonmaskable request edge is chosen by a system control select bit.
// - Pin requests are forwarded only when enabled; flags kept regardless.
// - Detection does not depend on the pin direction setting.
// - All seven external interrupts can wake the chip from standby.
// - Internal request issues only when its flag and enable are both one.
// - Transfer controller requests bypass control mode and CPU mask.
// - One enable bit per pin, one enables, all reset to zero.
// - Priority fields are 3 bits, 000 lowest to 111 highest, reset 111.
`ifndef EISF_CFG_SVH
`define EISF_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EISF_OFS_SENSE    4'h0
`define EISF_OFS_STATUS   4'h4
`define EISF_OFS_ENABLE   4'h8
`define EISF_OFS_SYSCTL   4'hC

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define EISF_SENSE_MASK   16'h0FFF
`define EISF_PIN_MASK     8'h3F
`define EISF_SENSE_RST    16'h0000
`define EISF_STATUS_RST   6'h00
`define EISF_ENABLE_RST   6'h00
`define EISF_NM_EDGE_BIT  0
`define EISF_NM_EDGE_RST  1'b0
`define EISF_PRIO_RST     3'h7
`define EISF_PRIO_LSB     8
`define EISF_PIN_IDLE     6'h3F
`define EISF_NM_IDLE      1'b1

`endif

// file: include/eisf_pkg.sv
/*
 Types of the external interrupt front end.
 Assumes eisf_cfg.svh is on the include path.
*/
package eisf_pkg;

	typedef enum logic [1:0] {
		EISF_LOW_LEVEL,
		EISF_FALL,
		EISF_RISE,
		EISF_BOTH
	} eisf_sense_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} eisf_bus_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic        readdatavalid;
		logic [31:0] readdata;
	} eisf_bus_rsp_t;

	typedef enum {
		EISF_IDLE,
		EISF_DONE
	} eisf_bus_st_t;

	typedef struct packed {
		logic [5:0]    pin_s1;
		logic [5:0]    pin_s2;
		logic [5:0]    pin_prev;
		logic          nm_s1;
		logic          nm_s2;
		logic          nm_prev;
		logic [15:0]   sense_select_low;
		logic [5:0]    pin_request_status;
		logic [5:0]    pin_request_enable;
		logic          nonmask_edge_select;
		logic [17:0]   priority_level_reg;
		logic [5:0]    pin_req;
		logic          nm_req;
		logic          wake;
		logic [31:0]   int_req;
		logic [31:0]   dtc_req;
		eisf_bus_st_t  bus_st;
		eisf_bus_rsp_t rsp;
	} eisf_state_t;

endpackage : eisf_pkg

// file: design/eisf_ext_irq.sv
/*
 External interrupt front end: pin synchronisers, sense decoding, status
 flags, enables, nonmaskable edge select and internal request gating, all
 behind an Avalon-MM slave.
 Assumes the CPU core pulses handling acknowledges and the transfer
 controller pulses its activation strobes, both on clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "eisf_cfg.svh"

module eisf_ext_irq
	import eisf_pkg::*;
#(
	parameter int N_INT = 32
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire eisf_bus_req_t    avs_req,
	output var  eisf_bus_rsp_t    avs_rsp,
	input  wire logic             nonmask_pin,
	input  wire logic [5:0]       ext_req_pin_n,
	input  wire logic [5:0]       cpu_handle_ack,
	input  wire logic [5:0]       dtc_activate,
	input  wire logic             transfer_end_disable,
	input  wire logic [N_INT-1:0] int_flag,
	input  wire logic [N_INT-1:0] int_enable,
	input  wire logic [N_INT-1:0] int_dtc_select,
	output logic                  nonmask_req,
	output logic [5:0]            pin_req,
	output logic                  standby_wake,
	output logic [N_INT-1:0]      int_req,
	output logic [N_INT-1:0]      dtc_req
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic sense_hit(input logic [1:0] code, input logic cur,
	                                   input logic prev);
		case (eisf_sense_t'(code))
			EISF_LOW_LEVEL: sense_hit = ~cur;
			EISF_FALL:      sense_hit = prev & ~cur;
			EISF_RISE:      sense_hit = ~prev & cur;
			EISF_BOTH:      sense_hit = prev ^ cur;
			default:        sense_hit = 1'b0;
		endcase
	endfunction : sense_hit

	function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] nw,
	                                          input logic be);
		lane_merge = be ? nw : old;
	endfunction : lane_merge

	function automatic logic [31:0] sysctl_word(input logic edge_sel,
	                                            input logic [17:0] prio);
		sysctl_word = 32'h0000_0000;
		sysctl_word[`EISF_NM_EDGE_BIT] = edge_sel;
		sysctl_word[`EISF_PRIO_LSB +: 18] = prio;
	endfunction : sysctl_word

	eisf_state_t s_r;
	eisf_state_t s_nxt;

	logic [5:0] hit;
	logic [5:0] clr_hw;
	logic       wr_hit;
	logic [7:0] st_wr;
	logic [7:0] en_wr;
	logic [15:0] sn_wr;
	logic [31:0] sc_cur;
	logic [31:0] sc_wr;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		hit = '0;
		clr_hw = '0;
		wr_hit = 1'b0;
		st_wr = 8'h00;
		en_wr = 8'h00;
		sn_wr = 16'h0000;
		sc_cur = sysctl_word(s_r.nonmask_edge_select, s_r.priority_level_reg);
		sc_wr = 32'h0000_0000;

		// Two synchroniser flops per pin; the second stage and pin_prev feed logic
		s_nxt.pin_s1   = ext_req_pin_n;
		s_nxt.pin_s2   = s_r.pin_s1;
		s_nxt.pin_prev = s_r.pin_s2;
		s_nxt.nm_s1    = nonmask_pin;
		s_nxt.nm_s2    = s_r.nm_s1;
		s_nxt.nm_prev  = s_r.nm_s2;

		// Pin level is read from the second synchroniser stage, direction plays no part
		for (int i = 0; i < 6; i++) begin
			hit[i] = sense_hit(s_r.sense_select_low[2*i +: 2], s_r.pin_s2[i],
			                   s_r.pin_prev[i]);
			if (s_r.sense_select_low[2*i +: 2] == 2'b00) begin
				clr_hw[i] = cpu_handle_ack[i] & s_r.pin_s2[i];
			end else begin
				clr_hw[i] = cpu_handle_ack[i];
			end
			if (dtc_activate[i] && !transfer_end_disable) begin
				clr_hw[i] = 1'b1;
			end
		end

		// ----------------------------------------------------------------
		// Bus slave: one wait cycle, answer in the second
		// ----------------------------------------------------------------
		s_nxt.rsp.readdatavalid = 1'b0;
		case (s_r.bus_st)
			EISF_IDLE: begin
				s_nxt.rsp.waitrequest = 1'b1;
				if (avs_req.read || avs_req.write) begin
					s_nxt.bus_st = EISF_DONE;
					s_nxt.rsp.waitrequest = 1'b0;
					s_nxt.rsp.readdata = 32'h0000_0000;
					case (avs_req.address)
						`EISF_OFS_SENSE:  s_nxt.rsp.readdata[15:0] = s_r.sense_select_low;
						`EISF_OFS_STATUS: s_nxt.rsp.readdata[5:0] = s_r.pin_request_status;
						`EISF_OFS_ENABLE: s_nxt.rsp.readdata[5:0] = s_r.pin_request_enable;
						`EISF_OFS_SYSCTL: s_nxt.rsp.readdata = sc_cur;
						default:          s_nxt.rsp.readdata = 32'h0000_0000;
					endcase
				end
			end
			EISF_DONE: begin
				// Write lands at the edge where waitrequest is seen low
				s_nxt.bus_st = EISF_IDLE;
				s_nxt.rsp.waitrequest = 1'b1;
				s_nxt.rsp.readdatavalid = avs_req.read;
				wr_hit = avs_req.write;
			end
			default: begin
				s_nxt.bus_st = EISF_IDLE;
				s_nxt.rsp.waitrequest = 1'b1;
			end
		endcase

		// Unused bits are forced to zero, so stray writes cannot matter
		sn_wr = {lane_merge(s_r.sense_select_low[15:8], avs_req.writedata[15:8],
		                    avs_req.byteenable[1]),
		         lane_merge(s_r.sense_select_low[7:0], avs_req.writedata[7:0],
		                    avs_req.byteenable[0])} & `EISF_SENSE_MASK;
		st_wr = avs_req.byteenable[0] ? avs_req.writedata[7:0] : 8'hFF;
		en_wr = avs_req.writedata[7:0] & `EISF_PIN_MASK;

		if (wr_hit && avs_req.address == `EISF_OFS_SENSE) begin
			s_nxt.sense_select_low = sn_wr;
		end
		if (wr_hit && avs_req.address == `EISF_OFS_ENABLE && avs_req.byteenable[0]) begin
			s_nxt.pin_request_enable = en_wr[5:0];
		end
		sc_wr = {lane_merge(sc_cur[31:24], avs_req.writedata[31:24], avs_req.byteenable[3]),
		         lane_merge(sc_cur[23:16], avs_req.writedata[23:16], avs_req.byteenable[2]),
		         lane_merge(sc_cur[15:8], avs_req.writedata[15:8], avs_req.byteenable[1]),
		         lane_merge(sc_cur[7:0], avs_req.writedata[7:0], avs_req.byteenable[0])};
		if (wr_hit && avs_req.address == `EISF_OFS_SYSCTL) begin
			s_nxt.nonmask_edge_select = sc_wr[`EISF_NM_EDGE_BIT];
			// Priority fields are only held here and read back over the bus; no port carries them out
			s_nxt.priority_level_reg = sc_wr[`EISF_PRIO_LSB +: 18];
		end

		// Clear by zero write or hardware; a new hit in the same cycle wins
		if (wr_hit && avs_req.address == `EISF_OFS_STATUS) begin
			s_nxt.pin_request_status = s_r.pin_request_status & st_wr[5:0];
		end
		s_nxt.pin_request_status = (s_nxt.pin_request_status & ~clr_hw) | hit;

		// ----------------------------------------------------------------
		// Outputs toward the CPU and the transfer controller
		// ----------------------------------------------------------------
		s_nxt.pin_req = s_nxt.pin_request_status & s_r.pin_request_enable;
		// Edge polarity: 1 selects rising, 0 falling
		s_nxt.nm_req = s_r.nonmask_edge_select ? (~s_r.nm_prev & s_r.nm_s2)
		                                       : (s_r.nm_prev & ~s_r.nm_s2);
		s_nxt.wake = s_nxt.nm_req | (|hit);
		s_nxt.int_req = int_flag & int_enable & ~int_dtc_select;
		s_nxt.dtc_req = int_flag & int_enable & int_dtc_select;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			s_r                     <= '0;
			// Chains start at the idle level, so release shows no false edge
			s_r.pin_s1              <= `EISF_PIN_IDLE;
			s_r.pin_s2              <= `EISF_PIN_IDLE;
			s_r.pin_prev            <= `EISF_PIN_IDLE;
			s_r.nm_s1               <= `EISF_NM_IDLE;
			s_r.nm_s2               <= `EISF_NM_IDLE;
			s_r.nm_prev             <= `EISF_NM_IDLE;
			s_r.sense_select_low    <= `EISF_SENSE_RST;
			s_r.pin_request_status  <= `EISF_STATUS_RST;
			s_r.pin_request_enable  <= `EISF_ENABLE_RST;
			s_r.nonmask_edge_select <= `EISF_NM_EDGE_RST;
			s_r.priority_level_reg  <= {6{`EISF_PRIO_RST}};
			s_r.bus_st              <= EISF_IDLE;
			s_r.rsp.waitrequest     <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_rsp      = s_r.rsp;
	assign nonmask_req  = s_r.nm_req;
	assign pin_req      = s_r.pin_req;
	assign standby_wake = s_r.wake;
	assign int_req      = s_r.int_req[N_INT-1:0];
	assign dtc_req      = s_r.dtc_req[N_INT-1:0];

endmodule : eisf_ext_irq
`default_nettype wire

// file: verif/eisf_checker.sv
/* Port assertions for eisf_ext_irq.
 Assumes it is bound to the design and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module eisf_checker
	import eisf_pkg::*;
#(parameter int N_INT = 32) (
	input wire logic             clk,
	input wire logic             srst,
	input wire eisf_bus_req_t    avs_req,
	input wire eisf_bus_rsp_t    avs_rsp,
	input wire logic             nonmask_pin,
	input wire logic [5:0]       ext_req_pin_n,
	input wire logic [N_INT-1:0] int_flag,
	input wire logic [N_INT-1:0] int_enable,
	input wire logic [N_INT-1:0] int_dtc_select,
	input wire logic             nonmask_req,
	input wire logic             standby_wake,
	input wire logic [N_INT-1:0] int_req,
	input wire logic [N_INT-1:0] dtc_req
);
	logic rq;
	logic wt;
	assign rq = avs_req.read | avs_req.write;
	assign wt = avs_rsp.waitrequest;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_take; rq && wt |=> !wt; endproperty
	a_take: assert property (p_take) else $error("access not answered");
	property p_one; !wt |=> wt; endproperty
	a_one: assert property (p_one) else $error("answer held too long");
	property p_idle; !rq && wt |=> wt; endproperty
	a_idle: assert property (p_idle) else $error("answer without access");
	property p_int; !$past(srst) |-> int_req == $past(int_flag & int_enable & ~int_dtc_select);
	endproperty
	a_int: assert property (p_int) else $error("internal request gating");
	property p_dtc; !$past(srst) |-> dtc_req == $past(int_flag & int_enable & int_dtc_select);
	endproperty
	a_dtc: assert property (p_dtc) else $error("transfer request routing");
	property p_nm1; nonmask_req |=> !nonmask_req; endproperty
	a_nm1: assert property (p_nm1) else $error("nonmaskable pulse too long");
	property p_nmw; nonmask_req |-> standby_wake; endproperty
	a_nmw: assert property (p_nmw) else $error("nonmaskable without wake");
	property p_nmq; $stable(nonmask_pin) [*6] |=> !nonmask_req; endproperty
	a_nmq: assert property (p_nmq) else $error("nonmaskable without edge");
	property p_wq; (&{nonmask_pin, ext_req_pin_n}) [*6] |=> !standby_wake; endproperty
	a_wq: assert property (p_wq) else $error("wake while pins idle");
endmodule : eisf_checker
bind eisf_ext_irq eisf_checker #(.N_INT(N_INT)) u_chk (.clk, .srst, .avs_req, .avs_rsp,
	.nonmask_pin, .ext_req_pin_n, .int_flag, .int_enable, .int_dtc_select, .nonmask_req,
	.standby_wake, .int_req, .dtc_req);
`default_nettype wire

// file: verif/eisf_far_model.sv
/* CPU core and transfer controller stand-in: acknowledges the lowest
 pending pin request, promptly or slowly. Assumes pin_req is registered. */
`timescale 1ns/1ns
`default_nettype none
module eisf_far_model (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       use_dtc,
	input  wire logic       slow,
	input  wire logic [5:0] pin_req,
	output logic      [5:0] cpu_handle_ack,
	output logic      [5:0] dtc_activate
);
	logic [2:0] wait_r;
	logic [5:0] pick;
	assign pick = pin_req & (~pin_req + 6'h01);
	// Count restarts after each pulse, so a flag not yet cleared is not acked twice
	always_ff @(posedge clk) begin
		cpu_handle_ack <= 6'h00;
		dtc_activate   <= 6'h00;
		wait_r         <= (srst || pick == 6'h00) ? 3'h0 : wait_r + 3'h1;
		if (!srst && pick != 6'h00 && wait_r == (slow ? 3'h5 : 3'h1)) begin
			wait_r <= 3'h0;
			if (use_dtc)
				dtc_activate <= pick;
			else
				cpu_handle_ack <= pick;
		end
	end
endmodule : eisf_far_model
`default_nettype wire

// file: verif/eisf_ext_irq_tb.sv
/* Self-checking bench: Avalon-MM register access, sense modes, flag
 clearing by the far model, nonmaskable edges, internal gating.
 Assumes the checker binds itself from its own file. */
`timescale 1ns/1ns
`default_nettype none
module eisf_ext_irq_tb
	import eisf_pkg::*;
;
	logic          clk, srst, nm, use_dtc, slow, ted, nm_req, wake;
	logic [5:0]    pins, ack, act, preq, ea, eb, ec;
	logic [11:0]   sv;
	logic [31:0]   flg, ena, sel, ireq, dreq, q;
	eisf_bus_req_t req;
	eisf_bus_rsp_t rsp;
	int            n_fail, checks, nm_cnt, wk_cnt;
	eisf_ext_irq dut (.clk, .srst, .avs_req(req), .avs_rsp(rsp), .nonmask_pin(nm),
		.ext_req_pin_n(pins), .cpu_handle_ack(ack), .dtc_activate(act),
		.transfer_end_disable(ted), .int_flag(flg), .int_enable(ena), .int_dtc_select(sel),
		.nonmask_req(nm_req), .pin_req(preq), .standby_wake(wake), .int_req(ireq),
		.dtc_req(dreq));
	eisf_far_model far (.clk, .srst, .use_dtc, .slow, .pin_req(preq), .cpu_handle_ack(ack),
		.dtc_activate(act));
	always #4 clk = ~clk;
	always @(posedge clk) if (nm_req === 1'b1) nm_cnt++;
	always @(posedge clk) if (wake === 1'b1) wk_cnt++;
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : ck
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		req <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: d};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (rsp.waitrequest !== 1'b0 && i < 50);
		q = rsp.readdata;
		if (rsp.waitrequest !== 1'b0) begin
			n_fail++;
			complete_run();
		end
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
	endtask : acc
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		ck(q, e);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	initial begin
		{clk, srst, nm, use_dtc, slow, ted, pins} = {6'h18, 6'h3F};
		{flg, ena, sel, req} = '0;
		{n_fail, checks, nm_cnt, wk_cnt} = '0;
		cyc(8);
		srst <= 1'b0;
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		rd(4'hC, 32'h03FFFF00);
		acc(1'b1, 4'h2, 32'hFFFFFFFF);
		rd(4'h2, 32'h0);
		acc(1'b1, 4'h0, 32'h00000FFF);
		rd(4'h0, 32'h00000FFF);
		acc(1'b1, 4'h8, 32'h000000FF);
		rd(4'h8, 32'h0000003F);
		acc(1'b1, 4'h8, 32'h0);
		// Every code on every pin, flags kept while requests are disabled
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 6; k++) begin
				sv[2*k+:2] = 2'(m + k);
				ea[k] = sv[2*k+:2] != 2'h2;
				eb[k] = sv[2*k+:2] == 2'h0;
				ec[k] = sv[2*k+1];
			end
			acc(1'b1, 4'h0, {20'h0, sv});
			acc(1'b1, 4'h4, 32'h0);
			pins <= 6'h00;
			cyc(6);
			rd(4'h4, {26'h0, ea});
			ck({26'h0, preq}, 32'h0);
			acc(1'b1, 4'h4, 32'h0);
			rd(4'h4, {26'h0, eb});
			pins <= 6'h3F;
			cyc(6);
			rd(4'h4, {26'h0, eb | ec});
		end
		acc(1'b1, 4'h8, 32'h3F);
		acc(1'b1, 4'h0, 32'h555);
		pins <= 6'h00;
		cyc(40);
		rd(4'h4, 32'h0);
		slow <= 1'b1;
		acc(1'b1, 4'h0, 32'h0);
		cyc(20);
		rd(4'h4, 32'h3F);
		pins <= 6'h3F;
		cyc(80);
		rd(4'h4, 32'h0);
		slow <= 1'b0;
		use_dtc <= 1'b1;
		ted <= 1'b1;
		acc(1'b1, 4'h0, 32'h555);
		pins <= 6'h00;
		cyc(20);
		rd(4'h4, 32'h3F);
		ck({26'h0, preq}, 32'h3F);
		ted <= 1'b0;
		cyc(40);
		rd(4'h4, 32'h0);
		// Pins are steady here, so every wake pulse must come from the nonmaskable pin
		wk_cnt = 0;
		nm <= 1'b0;
		cyc(8);
		nm <= 1'b1;
		cyc(8);
		ck(nm_cnt, 32'h1);
		ck(wk_cnt, 32'h1);
		acc(1'b1, 4'hC, 32'h1);
		rd(4'hC, 32'h1);
		nm <= 1'b0;
		cyc(8);
		nm <= 1'b1;
		cyc(8);
		ck(nm_cnt, 32'h2);
		ck(wk_cnt, 32'h2);
		flg <= 32'hFFFFFFFF;
		ena <= 32'h0000FFFF;
		sel <= 32'h00FF00FF;
		cyc(2);
		ck(ireq, 32'h0000FF00);
		ck(dreq, 32'h000000FF);
		complete_run();
	end
endmodule : eisf_ext_irq_tb
`default_nettype wire
